//--- verilog/scs_clock_select.v
/*
 System clock select and switch: picks the device clock from the
 primary, secondary and internal sources, divides the internal
 source, pauses glitch-free on a switch, reports the active source
 and gates the oscillators but the secondary, and the RC source while the watchdog is on, by power state. Device clocks are
 one-cycle enable pulses on mclk.
 Assumes configuration inputs are static and that start-up timer
 and stability inputs come from logic on mclk.
*/
`timescale 1ns/1ps
`include "scs_consts.vh"

module scs_clock_select (
	// Clock and reset
	input  wire       mclk,
	input  wire       rst_b,
	// Register port
	input  wire [1:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	// Configuration
	input  wire       switchover_config,
	input  wire [3:0] primary_mode_config,
	input  wire       watchdog_enable,
	// Oscillator pins
	input  wire       primary_osc_in,
	input  wire       secondary_osc_in,
	input  wire       internal_8mhz_source_in,
	input  wire       internal_31khz_rc_source_in,
	// Source state
	input  wire       ost_expired,
	input  wire       internal_8mhz_source_stable,
	// Power events
	input  wire       sleep_exec,
	input  wire       wake_event,
	// Clock enables to the device
	output wire       cpu_clk_en,
	output wire       periph_clk_en,
	output wire       watchdog_clk_en,
	// Oscillator gating
	output reg        primary_osc_en,
	output reg        secondary_osc_en,
	output reg        internal_8mhz_source_en,
	output reg        internal_31khz_rc_source_en,
	output reg        multiplier_run,
	output reg  [1:0] power_state
);

// Switch states
localparam SW_RUN   = 2'd0;
localparam SW_DRAIN = 2'd1;
localparam SW_SYNC  = 2'd2;

reg  [1:0] system_clock_select;
reg  [2:0] internal_freq_select;
reg        idle_enable;
reg        low_freq_source_bit;
reg        multiplier_enable;
reg  [4:0] tune_value;
reg        secondary_osc_enable;
reg        primary_running_status;
reg  [1:0] active_src;
reg  [1:0] sw_state;
reg  [1:0] sw_count;
reg  [7:0] post_cnt;
wire       pri_tick;
wire       sec_tick;
wire       iosc_tick;
wire       rc_tick;
wire       int_tick;
wire       old_tick;
wire       new_tick;
wire       dev_tick;
wire       rc_direct;
wire       int_cfg;
wire       mult_ok;
wire       internal_stable_status;
wire       secondary_running_status;
wire       sel_write;
wire [1:0] wr_sel;
wire [1:0] next_sel;

////////////////////////////////////////////////////////////////////////
// Functions

// Postscaler mask: tick when the low counter bits are all ones
function [7:0] post_mask;
	input [2:0] code;
	begin
		case (code)
		3'h7:    post_mask = 8'h00; // 8 MHz direct
		3'h6:    post_mask = 8'h01;
		3'h5:    post_mask = 8'h03;
		3'h4:    post_mask = 8'h07;
		3'h3:    post_mask = 8'h0f;
		3'h2:    post_mask = 8'h1f;
		3'h1:    post_mask = 8'h3f;
		default: post_mask = 8'hff; // Divide by 256
		endcase
	end
endfunction

// Tick of a source by its select code
function src_tick;
	input [1:0] src;
	input       p;
	input       s;
	input       i;
	begin
		case (src)
		`SCS_SRC_PRI: src_tick = p;
		`SCS_SRC_SEC: src_tick = s;
		default:      src_tick = i;
		endcase
	end
endfunction

// Collapse 1x onto one internal code
function [1:0] src_code;
	input [1:0] sel;
	begin
		src_code = sel[1] ? `SCS_SRC_INT : sel;
	end
endfunction

////////////////////////////////////////////////////////////////////////
// Oscillator pin sampling

scs_edge_sync u_pri (
	.mclk     (mclk),
	.rst_b    (rst_b),
	.osc_in   (primary_osc_in),
	.osc_tick (pri_tick)
);

scs_edge_sync u_sec (
	.mclk     (mclk),
	.rst_b    (rst_b),
	.osc_in   (secondary_osc_in),
	.osc_tick (sec_tick)
);

scs_edge_sync u_iosc (
	.mclk     (mclk),
	.rst_b    (rst_b),
	.osc_in   (internal_8mhz_source_in),
	.osc_tick (iosc_tick)
);

scs_edge_sync u_rc (
	.mclk     (mclk),
	.rst_b    (rst_b),
	.osc_in   (internal_31khz_rc_source_in),
	.osc_tick (rc_tick)
);

////////////////////////////////////////////////////////////////////////
// Internal block output

// Code 000 with the low-frequency bit clear bypasses the postscaler
assign rc_direct = (internal_freq_select == `SCS_FREQ_31K) && !low_freq_source_bit;

// Mask read live, so a new code acts on the next source edge
assign int_tick = rc_direct ? rc_tick :
	(iosc_tick && ((post_cnt & post_mask(internal_freq_select)) ==
	post_mask(internal_freq_select)));

// Free-running postscaler on the 8 MHz source
always @(posedge mclk) begin
	if (!rst_b) begin
		post_cnt <= 8'h00;
	end else if (iosc_tick) begin
		post_cnt <= post_cnt + 8'h01;
	end
end

// The RC source clocks the watchdog whatever the select
assign watchdog_clk_en = rc_tick;

////////////////////////////////////////////////////////////////////////
// Register writes

// A secondary select with its oscillator off keeps the old value
assign wr_sel    = reg_wdata[`SCS_SEL_HI:`SCS_SEL_LO];
assign sel_write = reg_wr && (reg_addr == `SCS_REG_OSC_CTRL) &&
	!((wr_sel == `SCS_SRC_SEC) && !secondary_osc_enable);
assign next_sel  = sel_write ? wr_sel : system_clock_select;

always @(posedge mclk) begin
	if (!rst_b) begin
		system_clock_select  <= `SCS_SEL_RST;
		internal_freq_select <= `SCS_FREQ_RST;
		idle_enable          <= 1'b0;
		low_freq_source_bit  <= 1'b0;
		multiplier_enable    <= 1'b0;
		tune_value           <= 5'h00;
		secondary_osc_enable <= 1'b0;
	end else begin
		system_clock_select <= next_sel;
		if (reg_wr && (reg_addr == `SCS_REG_OSC_CTRL)) begin
			idle_enable          <= reg_wdata[`SCS_IDLE_BIT];
			internal_freq_select <= reg_wdata[`SCS_FREQ_HI:`SCS_FREQ_LO];
		end
		if (reg_wr && (reg_addr == `SCS_REG_OSC_TUNE)) begin
			low_freq_source_bit <= reg_wdata[`SCS_LFSRC_BIT];
			multiplier_enable   <= reg_wdata[`SCS_MULT_BIT];
			tune_value          <= reg_wdata[`SCS_TUNE_HI:0];
		end
		if (reg_wr && (reg_addr == `SCS_REG_TMR_CTRL)) begin
			secondary_osc_enable <= reg_wdata[`SCS_SEC_EN_BIT];
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Glitch-free switch

// Old source is gated first, then the new one is counted in
assign old_tick = src_tick(active_src, pri_tick, sec_tick, int_tick);
assign new_tick = src_tick(src_code(system_clock_select),
	pri_tick, sec_tick, int_tick);

// Device clock runs only outside a switch, so no runt pulse escapes
assign dev_tick = (sw_state == SW_RUN) && old_tick;

// Pause: two old-source edges, then three new-source edges; the
// fourth comes from phase of the new source against the handover
always @(posedge mclk) begin
	if (!rst_b) begin
		active_src <= `SCS_SRC_PRI;
		sw_state   <= SW_RUN;
		sw_count   <= 2'h0;
	end else begin
		case (sw_state)
		SW_RUN: begin
			if (src_code(system_clock_select) != active_src) begin
				sw_state <= SW_DRAIN;
				sw_count <= 2'h0;
			end
		end
		SW_DRAIN: begin
			if (old_tick) begin
				if (sw_count == `SCS_OLD_CYCLES - 2'h1) begin
					sw_state <= SW_SYNC;
					sw_count <= 2'h0;
				end else begin
					sw_count <= sw_count + 2'h1;
				end
			end
		end
		SW_SYNC: begin
			if (new_tick) begin
				if (sw_count == `SCS_NEW_CYCLES - 2'h1) begin
					active_src <= src_code(system_clock_select);
					sw_state   <= SW_RUN;
				end else begin
					sw_count <= sw_count + 2'h1;
				end
			end
		end
		default: begin
			sw_state <= SW_RUN;
			sw_count <= 2'h0;
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// Power state

// Sleep instruction goes to idle or sleep; any wake event returns
always @(posedge mclk) begin
	if (!rst_b) begin
		power_state <= `SCS_PWR_RUN;
	end else if (wake_event) begin
		power_state <= `SCS_PWR_RUN;
	end else if (sleep_exec && (power_state == `SCS_PWR_RUN)) begin
		power_state <= idle_enable ? `SCS_PWR_IDLE : `SCS_PWR_SLEEP;
	end
end

// CPU runs only in run; peripherals also in idle
assign cpu_clk_en    = dev_tick && (power_state == `SCS_PWR_RUN);
assign periph_clk_en = dev_tick && (power_state != `SCS_PWR_SLEEP);

////////////////////////////////////////////////////////////////////////
// Oscillator gating

assign int_cfg = (primary_mode_config == `SCS_CFG_INT_A) ||
	(primary_mode_config == `SCS_CFG_INT_B);
assign mult_ok = int_cfg && ((internal_freq_select == `SCS_FREQ_8M) ||
	(internal_freq_select == `SCS_FREQ_4M));

// Registered enables; outside sleep a source stays on while it is old or new, the secondary by its enable bit alone
always @(posedge mclk) begin
	if (!rst_b) begin
		primary_osc_en   <= 1'b1;
		secondary_osc_en <= 1'b0;
		internal_8mhz_source_en        <= 1'b0;
		internal_31khz_rc_source_en         <= 1'b0;
		multiplier_run   <= 1'b0;
	end else begin
		primary_osc_en <= (power_state != `SCS_PWR_SLEEP) &&
			((active_src == `SCS_SRC_PRI) ||
			(src_code(system_clock_select) == `SCS_SRC_PRI));
		// Kept on in sleep too, for the timers it clocks
		secondary_osc_en <= secondary_osc_enable;
		internal_8mhz_source_en <= (power_state != `SCS_PWR_SLEEP) && !rc_direct &&
			((active_src == `SCS_SRC_INT) ||
			(src_code(system_clock_select) == `SCS_SRC_INT) ||
			(int_cfg && (active_src == `SCS_SRC_PRI)));
		internal_31khz_rc_source_en <= watchdog_enable || ((power_state != `SCS_PWR_SLEEP) &&
			rc_direct && ((active_src == `SCS_SRC_INT) ||
			(src_code(system_clock_select) == `SCS_SRC_INT)));
		multiplier_run <= multiplier_enable && mult_ok &&
			(active_src == `SCS_SRC_PRI) &&
			(power_state != `SCS_PWR_SLEEP);
	end
end

////////////////////////////////////////////////////////////////////////
// Status

// Each status needs its own source active and no switch underway
assign internal_stable_status = internal_8mhz_source_stable && !rc_direct &&
	(active_src == `SCS_SRC_INT) && (sw_state == SW_RUN);
assign secondary_running_status = (active_src == `SCS_SRC_SEC) &&
	(sw_state == SW_RUN);

// With two-speed start-up the primary is not yet ready at reset
always @(posedge mclk) begin
	if (!rst_b) begin
		primary_running_status <= !switchover_config;
	end else begin
		primary_running_status <= ost_expired &&
			(active_src == `SCS_SRC_PRI) && (sw_state == SW_RUN);
	end
end

////////////////////////////////////////////////////////////////////////
// Register reads

// Data stand in the cycle after the strobe only; unmapped reads 0
always @(posedge mclk) begin
	if (!rst_b) begin
		reg_rdata <= 8'h00;
	end else if (reg_rd) begin
		case (reg_addr)
		`SCS_REG_OSC_CTRL:
			reg_rdata <= {idle_enable, internal_freq_select,
				primary_running_status, internal_stable_status,
				system_clock_select};
		`SCS_REG_OSC_TUNE:
			reg_rdata <= {low_freq_source_bit,
				multiplier_enable && int_cfg, 1'b0, tune_value};
		`SCS_REG_TMR_CTRL:
			reg_rdata <= {1'b0, secondary_running_status, 2'b00,
				secondary_osc_enable, 3'b000};
		`SCS_REG_PWR_STAT:
			reg_rdata <= {2'b00, active_src, 2'b00, power_state};
		default:
			reg_rdata <= 8'h00;
		endcase
	end else begin
		reg_rdata <= 8'h00;
	end
end

endmodule // scs_clock_select

//--- verilog/scs_consts.vh
/*
 Constants of the system clock select block: register indices,
 field positions, reset values, source and mode codes.
 Assumes inclusion by bare name from the block's design files.
*/
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH

// Register indices on the plain register port
`define SCS_REG_OSC_CTRL   2'h0
`define SCS_REG_OSC_TUNE   2'h1
`define SCS_REG_TMR_CTRL   2'h2
`define SCS_REG_PWR_STAT   2'h3

// Oscillator control fields
`define SCS_IDLE_BIT       7
`define SCS_FREQ_HI        6
`define SCS_FREQ_LO        4
`define SCS_PRI_STAT_BIT   3
`define SCS_INT_STAT_BIT   2
`define SCS_SEL_HI         1
`define SCS_SEL_LO         0

// Tuning and timer control fields
`define SCS_LFSRC_BIT      7
`define SCS_MULT_BIT       6
`define SCS_TUNE_HI        4
`define SCS_SECONDARY_RUN_MODE_BIT    6
`define SCS_SEC_EN_BIT     3

// Reset values
`define SCS_FREQ_RST       3'h4
`define SCS_SEL_RST        2'h0

// Clock select codes
`define SCS_SRC_PRI        2'h0
`define SCS_SRC_SEC        2'h1
`define SCS_SRC_INT        2'h2

// Internal frequency codes with special meaning
`define SCS_FREQ_8M        3'h7
`define SCS_FREQ_4M        3'h6
`define SCS_FREQ_31K       3'h0

// Primary mode configurations that use the internal block
`define SCS_CFG_INT_A      4'h9
`define SCS_CFG_INT_B      4'h8

// Power states
`define SCS_PWR_RUN        2'h0
`define SCS_PWR_IDLE       2'h1
`define SCS_PWR_SLEEP      2'h2

// Switch pause lengths in source cycles
`define SCS_OLD_CYCLES     2'h2
`define SCS_NEW_CYCLES     2'h3

`endif

//--- verilog/scs_edge_sync.v
/*
 Two-flop synchroniser and rising-edge detector for an oscillator
 pin sampled by mclk. Assumes the sampled clock runs well below
 half the mclk rate.
*/
`timescale 1ns/1ps

module scs_edge_sync (
	// Clock and reset
	input  wire mclk,
	input  wire rst_b,
	// Pin and edge pulse
	input  wire osc_in,
	output reg  osc_tick
);

reg s1;
reg s2;
reg s3;

////////////////////////////////////////////////////////////////////////
// Only s2 and s3 feed the edge compare; s1 is left to settle
always @(posedge mclk) begin
	if (!rst_b) begin
		s1       <= 1'b0;
		s2       <= 1'b0;
		s3       <= 1'b0;
		osc_tick <= 1'b0;
	end else begin
		s1       <= osc_in;
		s2       <= s1;
		s3       <= s2;
		osc_tick <= s2 & ~s3;
	end
end

endmodule // scs_edge_sync

//--- verification/scs_clock_select_sva.sv
/* Assertions on the ports of the clock select block.
 Assumes a bind onto scs_clock_select, one clock domain on mclk. */
`timescale 1ns/1ps
module scs_chk (
	// Clock, reset and bus
	input wire       mclk,
	input wire       rst_b,
	input wire [1:0] reg_addr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	// Configuration and events
	input wire [3:0] primary_mode_config,
	input wire       watchdog_enable,
	input wire       internal_31khz_rc_source_in,
	input wire       sleep_exec,
	input wire       wake_event,
	// Outputs under watch
	input wire       cpu_clk_en,
	input wire       periph_clk_en,
	input wire       watchdog_clk_en,
	input wire       primary_osc_en,
	input wire       internal_31khz_rc_source_en,
	input wire       multiplier_run,
	input wire [1:0] power_state
);
	// One domain; past-reset guards keep the release edges vacuous
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////
	// Assertions
	a_reset_state: assert property (disable iff (1'b0) !rst_b |=> primary_osc_en && power_state == 2'h0)
		else $error("reset state wrong");
	a_state_read: assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata[1:0] == $past(power_state))
		else $error("power state read wrong");
	a_wdt_keep: assert property ($past(rst_b) && $past(watchdog_enable) |-> internal_31khz_rc_source_en)
		else $error("rc source stopped with watchdog on");
	a_wdt_tick: assert property ($rose(internal_31khz_rc_source_in) |-> ##[2:4] watchdog_clk_en)
		else $error("watchdog tick missing");
	a_sleep_entry: assert property (sleep_exec && !wake_event && power_state == 2'h0 |=> power_state != 2'h0)
		else $error("sleep not taken");
	a_wake_run: assert property (wake_event |=> power_state == 2'h0)
		else $error("wake did not return to run");
	a_sleep_gate: assert property (power_state == 2'h2 |-> !cpu_clk_en && !periph_clk_en)
		else $error("tick during sleep");
	a_idle_gate: assert property (power_state == 2'h1 |-> !cpu_clk_en)
		else $error("cpu tick during idle");
	a_pri_off: assert property (power_state == 2'h2 && $past(power_state) == 2'h2 |-> !primary_osc_en)
		else $error("primary runs in sleep");
	a_mult_cfg: assert property (multiplier_run |-> primary_mode_config[3:1] == 3'h4)
		else $error("multiplier runs in wrong mode");
	// Main scenarios reached
	c_idle: cover property (power_state == 2'h1);
	c_sleep: cover property (power_state == 2'h2);
	c_wdt: cover property (watchdog_clk_en);
	c_mult: cover property (multiplier_run);
endmodule // scs_chk

//--- verification/scs_osc_model.sv
/* Oscillator sources facing the clock select block.
 Assumes enables from the block, registered on mclk. */
`timescale 1ns/1ps
module scs_osc_model (
	// Clock and reset
	input wire       mclk,
	input wire       rst_b,
	// Enables: bit 0 primary, 1 secondary, 2 internal 8 MHz, 3 RC
	input wire [3:0] osc_en,
	// Pins and source state
	output reg [3:0] osc_pin,
	output wire      ost_expired,
	output wire      internal_8mhz_source_stable
);
	// Half periods less one in mclk cycles, one nibble per source
	localparam [15:0] HALF = 16'h4162;
	reg [3:0] cnt [0:3];
	reg [5:0] run_pri;
	reg [5:0] run_int;
	integer   k;
	////////////////////////////////////////////////////////////
	// A stopped source stands low, so a gated pin cannot fake ticks
	always @(posedge mclk) begin
		for (k = 0; k < 4; k = k + 1) begin
			if (!rst_b || !osc_en[k]) begin
				cnt[k]     <= 4'h0;
				osc_pin[k] <= 1'b0;
			end else if (cnt[k] == HALF[k*4 +: 4]) begin
				cnt[k]     <= 4'h0;
				osc_pin[k] <= !osc_pin[k];
			end else begin
				cnt[k] <= cnt[k] + 4'h1;
			end
		end
	end
	// Start-up and stability flags rise after 32 cycles of running
	always @(posedge mclk) begin
		run_pri <= (!rst_b || !osc_en[0]) ? 6'h00 : run_pri + {5'h00, !run_pri[5]};
		run_int <= (!rst_b || !osc_en[2]) ? 6'h00 : run_int + {5'h00, !run_int[5]};
	end
	assign ost_expired   = run_pri[5];
	assign internal_8mhz_source_stable = run_int[5];
endmodule // scs_osc_model

//--- verification/testbench.sv
/* Self-checking bench of the clock select block.
 Assumes the oscillator model and the bound checker. */
`timescale 1ns/1ps
module testbench;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic [1:0]  reg_addr = 2'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        switchover_config = 1'b0;
	logic [3:0]  primary_mode_config = 4'h2;
	logic        watchdog_enable = 1'b1;
	logic        sleep_exec = 1'b0;
	logic        wake_event = 1'b0;
	wire [7:0]   reg_rdata;
	wire [3:0]   osc_en;
	wire [3:0]   osc_pin;
	wire [1:0]   power_state;
	wire         cpu_clk_en, periph_clk_en, watchdog_clk_en, multiplier_run, ost_expired, internal_8mhz_source_stable;
	int          n_mismatch = 0;
	int          checked = 0;
	int          cyc = 0;
	int          n;
	int          i;
	// Rows: address, write data, read mask, expected read
	logic [25:0] rows [0:6] = '{{2'h1, 8'hFF, 8'hFF, 8'h9F}, {2'h1, 8'h00, 8'hFF, 8'h00},
		{2'h2, 8'h08, 8'h08, 8'h08}, {2'h0, 8'h80, 8'hF3, 8'h80}, {2'h2, 8'h00, 8'h08, 8'h00},
		{2'h0, 8'h41, 8'h03, 8'h00}, {2'h0, 8'h4C, 8'hFF, 8'h48}};
	always #2 mclk = !mclk;
	////////////////////////////////////////////////////////////
	// Design and oscillator sources
	scs_clock_select dut_u (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .switchover_config(switchover_config),
		.primary_mode_config(primary_mode_config), .watchdog_enable(watchdog_enable),
		.primary_osc_in(osc_pin[0]),
		.secondary_osc_in(osc_pin[1]), .internal_8mhz_source_in(osc_pin[2]), .internal_31khz_rc_source_in(osc_pin[3]),
		.ost_expired(ost_expired), .internal_8mhz_source_stable(internal_8mhz_source_stable), .sleep_exec(sleep_exec),
		.wake_event(wake_event), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
		.watchdog_clk_en(watchdog_clk_en), .primary_osc_en(osc_en[0]), .secondary_osc_en(osc_en[1]),
		.internal_8mhz_source_en(osc_en[2]), .internal_31khz_rc_source_en(osc_en[3]), .multiplier_run(multiplier_run),
		.power_state(power_state));
	scs_osc_model osc_u (.mclk(mclk), .rst_b(rst_b), .osc_en(osc_en), .osc_pin(osc_pin),
		.ost_expired(ost_expired), .internal_8mhz_source_stable(internal_8mhz_source_stable));
	////////////////////////////////////////////////////////////
	// Comparisons and bus cycles
	task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked = checked + 1;
		if (g !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task cmpr(input string nm, input int lo, input int hi, input int g);
		checked = checked + 1;
		if (g < lo || g > hi) begin
			n_mismatch = n_mismatch + 1;
			$display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	// Strobes drop with a free cycle after, so no strobe is set twice in one step
	task wr(input [1:0] a, input [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task rdc(input [1:0] a, input [7:0] m, input [7:0] e);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 cmp("read data", e, reg_rdata & m);
		@(posedge mclk);
	endtask
	// Counts device ticks over a window
	task count(input bit per, input int len, output int t);
		t = 0;
		repeat (len) begin
			@(posedge mclk);
			#1 t = t + ((per ? periph_clk_en : cpu_clk_en) === 1'b1);
		end
	endtask
	// Cycles until the device clock resumes after a switch
	task gap(output int g);
		g = 0;
		@(posedge mclk);
		#1;
		while (cpu_clk_en !== 1'b1 && g < 400) begin
			@(posedge mclk);
			#1 g = g + 1;
		end
	endtask
	task ev(input bit s);
		sleep_exec <= s;
		wake_event <= !s;
		@(posedge mclk);
		sleep_exec <= 1'b0;
		wake_event <= 1'b0;
		@(posedge mclk);
		#1;
	endtask
	task do_reset(input bit sw);
		rst_b             <= 1'b0;
		switchover_config <= sw;
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
	endtask
	task print_verdict;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// Hang guard: the whole sequence needs about 10000 cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch = n_mismatch + 1;
			print_verdict;
		end
	end
	// Main sequence
	initial begin
		do_reset(1'b0);
		rdc(2'h0, 8'hFF, 8'h48);
		repeat (64) @(posedge mclk);
		for (i = 0; i < 7; i = i + 1) begin
			wr(rows[i][25:24], rows[i][23:16]);
			rdc(rows[i][25:24], rows[i][15:8], rows[i][7:0]);
		end
		wr(2'h0, 8'h72);
		gap(n);
		cmpr("switch pause", 8, 399, n);
		rdc(2'h3, 8'h30, 8'h20);
		repeat (64) @(posedge mclk);
		rdc(2'h0, 8'h0C, 8'h04);
		// Code 3 also selects the internal block, so no pause is expected
		for (i = 7; i > 0; i = i - 1) begin
			wr(2'h0, {1'b0, i[2:0], 4'h3});
			count(1'b0, 1024, n);
			cmpr("tick count", (256 >> (7 - i)) - 2, (256 >> (7 - i)) + 2, n);
		end
		wr(2'h1, 8'h80);
		wr(2'h0, 8'h02);
		count(1'b0, 1024, n);
		cmpr("divided tick count", 0, 2, n);
		wr(2'h1, 8'h00);
		count(1'b0, 1024, n);
		cmpr("rc tick count", 99, 105, n);
		cmp("internal_8mhz_source enable", 8'h00, {7'h00, osc_en[2]});
		// Secondary is enabled and left to start before it is selected
		wr(2'h2, 8'h08);
		repeat (64) @(posedge mclk);
		wr(2'h0, 8'h01);
		gap(n);
		cmpr("switch pause", 30, 399, n);
		rdc(2'h2, 8'h48, 8'h48);
		rdc(2'h0, 8'h0C, 8'h00);
		rdc(2'h3, 8'h30, 8'h10);
		wr(2'h0, 8'h81);
		ev(1'b1);
		cmp("power state", 8'h01, {6'h00, power_state});
		count(1'b1, 256, n);
		cmpr("idle ticks", 16, 20, n);
		ev(1'b0);
		wr(2'h0, 8'h01);
		ev(1'b1);
		cmp("power state", 8'h02, {6'h00, power_state});
		repeat (8) @(posedge mclk);
		cmp("osc enables", 8'h0A, {4'h0, osc_en});
		ev(1'b0);
		// Internal block as primary and watchdog off: multiplier allowed, RC source idle
		primary_mode_config <= 4'h9;
		watchdog_enable     <= 1'b0;
		do_reset(1'b1);
		rdc(2'h0, 8'hFF, 8'h40);
		wr(2'h1, 8'h40);
		rdc(2'h1, 8'hFF, 8'h40);
		cmp("multiplier run", 8'h00, {7'h00, multiplier_run});
		wr(2'h0, 8'h60);
		repeat (4) @(posedge mclk);
		#1 cmp("multiplier run", 8'h01, {7'h00, multiplier_run});
		cmp("osc enables", 8'h05, {4'h0, osc_en});
		print_verdict;
	end
endmodule // testbench

bind scs_clock_select scs_chk chk_u (.mclk, .rst_b, .reg_addr, .reg_rd, .reg_rdata, .primary_mode_config,
	.watchdog_enable, .internal_31khz_rc_source_in, .sleep_exec, .wake_event, .cpu_clk_en, .periph_clk_en, .watchdog_clk_en,
	.primary_osc_en, .internal_31khz_rc_source_en, .multiplier_run, .power_state);
